// File: bench/scan_engine_model.sv
// Behavioural scan engine on the far side of the sequencing control.
// Assumes start pulses on mclk; answers each with a done pulse after lat cycles.
`timescale 1ns/1ps
`default_nettype none
module scan_engine_model #(
	parameter int NG = 9
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic [NG-1:0] start,
	input wire logic [7:0] lat,
	output logic [NG-1:0] done
);
	logic [7:0] cnt_q [NG];
	// Latency set per run, so slow and prompt scans both occur
	always_ff @(posedge mclk) begin
		for (int i = 0; i < NG; i++) begin
			done[i] <= 1'b0;
			if (reset) begin
				cnt_q[i] <= 8'h00;
			end else if (start[i]) begin
				cnt_q[i] <= lat;
			end else if (cnt_q[i] != 8'h00) begin
				cnt_q[i] <= cnt_q[i] - 8'h01;
				done[i] <= (cnt_q[i] == 8'h01);
			end
		end
	end
endmodule : scan_engine_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking bench for the scan sequencing control.
// Assumes the design package and the scan engine model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import adc_seq_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [NUM_GROUPS-1:0] scan_trigger = '0;
	logic [NUM_GROUPS-1:0] scan_done;
	logic [NUM_GROUPS-1:0] scan_start;
	logic cmp_valid = 1'b0;
	logic cmp_a_hit = 1'b0;
	logic cmp_b_hit = 1'b0;
	logic scan_first, sync_enable, da_ad_reduce, sampling_enable, sampling_reinit, irq;
	logic [1:0] diag_voltage;
	logic [7:0] lat = 8'h04;
	int n_mismatch = 0;
	int checks_done = 0;
	logic [31:0] rd;
	logic seen;
	int g;
	int h;

	always #25 mclk = ~mclk;

	adc_scan_seq_ctrl #(.NG(NUM_GROUPS)) u_adc_scan_seq_ctrl (.mclk(mclk), .ce(ce),
		.reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .scan_trigger(scan_trigger), .scan_done(scan_done),
		.cmp_valid(cmp_valid), .cmp_a_hit(cmp_a_hit), .cmp_b_hit(cmp_b_hit),
		.scan_start(scan_start), .scan_first(scan_first), .diag_voltage(diag_voltage),
		.sync_enable(sync_enable), .da_ad_reduce(da_ad_reduce),
		.sampling_enable(sampling_enable), .sampling_reinit(sampling_reinit), .irq(irq));

	scan_engine_model #(.NG(NUM_GROUPS)) u_scan_engine_model (.mclk(mclk), .reset(reset),
		.start(scan_start), .lat(lat), .done(scan_done));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : check

	// Request held until waitrequest is seen low; data taken before that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		#1;
		while (avs_waitrequest !== 1'b0 && n < 40) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 40) n_mismatch++;
		rd = avs_readdata;
		@(posedge mclk);
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		#1;
	endtask : bus

	task automatic trig(input int grp, input logic es, input logic ef);
		@(posedge mclk);
		scan_trigger[grp] <= 1'b1;
		@(posedge mclk);
		scan_trigger <= '0;
		#1;
		check(32'(scan_start[grp]), 32'(es));
		if (es) check(32'(scan_first), 32'(ef));
	endtask : trig

	task automatic wait_done(input int grp);
		int n;
		n = 0;
		while (scan_done[grp] !== 1'b1 && n < 100) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 100) n_mismatch++;
		repeat (6) @(posedge mclk);
	endtask : wait_done

	task automatic end_of_test;
		$display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// Whole sequence needs a few thousand cycles at most
	initial begin
		#(50 * 20000);
		n_mismatch++;
		end_of_test;
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hE301));
		repeat (2) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		#1;
		check(32'(sync_enable), 32'h1);
		bus(1'b0, CTRL_OFFS, 32'h0);
		check(rd, 32'h010);
		bus(1'b0, STATE_OFFS, 32'h0);
		check(rd & 32'h1FFE, 32'h040);
		bus(1'b1, 8'h14, 32'hFFFF);
		bus(1'b0, 8'h14, 32'h0);
		check(rd, 32'h0);
		// No module stop is ever requested while reduction is set
		bus(1'b1, CTRL_OFFS, 32'h020);
		check(32'(da_ad_reduce), 32'h1);
		check(32'(sync_enable), 32'h0);
		g = $urandom_range(3, 1);
		bus(1'b1, CTRL_OFFS, 32'h010 | (g << 8));
		check(32'(diag_voltage), 32'h0);
		bus(1'b1, CTRL_OFFS, 32'h050);
		bus(1'b1, CTRL_OFFS, 32'h050 | (g << 8));
		check(32'(diag_voltage), 32'(g));
		bus(1'b1, IRQ_STAT_OFFS, 32'h3FF);
		bus(1'b1, IRQ_MASK_OFFS, 32'h200);
		bus(1'b1, CTRL_OFFS, 32'h011);
		g = $urandom_range(8, 0);
		lat <= 8'(8 + $urandom_range(7, 0));
		trig(g, 1'b1, 1'b1);
		trig(g, 1'b0, 1'b0);
		@(posedge mclk);
		#1;
		check(32'(irq), 32'h1);
		bus(1'b0, BUSY_OFFS, 32'h0);
		check(rd, 32'h1 << g);
		wait_done(g);
		bus(1'b0, IRQ_STAT_OFFS, 32'h0);
		check(rd & 32'h3FF, 32'h200 | (32'h1 << g));
		bus(1'b1, IRQ_STAT_OFFS, 32'h3FF);
		check(32'(irq), 32'h0);
		trig(g, 1'b1, 1'b0);
		wait_done(g);
		for (int i = 0; i < 6; i++) begin
			h = $urandom_range(8, 0);
			lat <= 8'($urandom_range(12, 1));
			trig(h, 1'b1, (i % 2) == 0);
			wait_done(h);
		end
		bus(1'b1, CTRL_OFFS, 32'h010);
		trig(g, 1'b1, 1'b0);
		wait_done(g);
		bus(1'b1, CTRL_OFFS, 32'h011);
		trig(g, 1'b1, 1'b1);
		wait_done(g);
		bus(1'b1, CTRL_OFFS, 32'h096);
		h = $urandom_range(1, 0);
		@(posedge mclk);
		cmp_valid <= 1'b1;
		cmp_a_hit <= 1'b1;
		cmp_b_hit <= h[0];
		@(posedge mclk);
		cmp_valid <= 1'b0;
		bus(1'b0, STATE_OFFS, 32'h0);
		check((rd >> 1) & 32'h7, 32'h5 | (h << 1));
		bus(1'b1, CTRL_OFFS, 32'h010);
		bus(1'b0, STATE_OFFS, 32'h0);
		check(rd & 32'hE, 32'h0);
		bus(1'b1, CTRL_OFFS, 32'h018);
		@(posedge mclk);
		#1;
		check(32'(sampling_enable), 32'h1);
		trig(g, 1'b1, 1'b0);
		wait_done(g);
		bus(1'b0, STATE_OFFS, 32'h0);
		check(32'(rd[12:9]), 32'h1);
		bus(1'b1, CTRL_OFFS, 32'h010);
		seen = 1'b0;
		repeat (5) begin
			@(posedge mclk);
			#1;
			if (sampling_reinit === 1'b1) seen = 1'b1;
		end
		check(32'(seen), 32'h1);
		bus(1'b0, STATE_OFFS, 32'h0);
		check((rd >> 6) & 32'h7F, 32'h1);
		@(posedge mclk);
		bus(1'b1, CTRL_OFFS, 32'h018);
		@(posedge mclk);
		#1;
		check(32'(sampling_enable), 32'h1);
		// Frozen enable: a trigger then must leave no trace
		@(posedge mclk);
		ce <= 1'b0;
		scan_trigger[g] <= 1'b1;
		@(posedge mclk);
		scan_trigger <= '0;
		@(posedge mclk);
		ce <= 1'b1;
		#1;
		check(32'(scan_start), 32'h0);
		bus(1'b0, BUSY_OFFS, 32'h0);
		check(rd, 32'h0);
		end_of_test;
	end
endmodule : tb_top
`default_nettype wire

// File: src/adc_scan_seq_ctrl.sv
// Scan sequencing control with an Avalon-MM register slave.
// Assumes triggers, done pulses and compare results come from mclk logic.

`timescale 1ns/1ps
`default_nettype none

module adc_scan_seq_ctrl #(
	parameter int NG = adc_seq_pkg::NUM_GROUPS
) (
	input wire logic mclk,
	input wire logic ce,
	input wire logic reset,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NG-1:0] scan_trigger,
	input wire logic [NG-1:0] scan_done,
	input wire logic cmp_valid,
	input wire logic cmp_a_hit,
	input wire logic cmp_b_hit,
	output logic [NG-1:0] scan_start,
	output logic scan_first,
	output logic [1:0] diag_voltage,
	output logic sync_enable,
	output logic da_ad_reduce,
	output logic sampling_enable,
	output logic sampling_reinit,
	output logic irq
);
	import adc_seq_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] offs);
		return a == offs;
	endfunction : addr_hit

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic ack_q, ack_d;
	logic [31:0] rdata_q, rdata_d;
	logic [31:0] rmux;
	logic wr_en, rd_start;
	ctrl_t ctrl_q, ctrl_d;
	logic [IRQ_W-1:0] mask_q, mask_d;
	logic [IRQ_W-1:0] istat_q, istat_d;
	logic [IRQ_W-1:0] iset, iclr;
	logic [31:0] ctrl_wr, mask_wr;
	state_t st;
	logic dbl_prev_q;
	logic pair_first_q, pair_first_d;
	logic dbl_rise, first_now, any_accept;
	logic mon_a_q, mon_a_d, mon_b_q, mon_b_d, mon_c_q, mon_c_d;
	logic [1:0] diag_q, diag_d;
	samp_state_t samp_q, samp_d;
	logic [SAMP_CNT_W-1:0] scnt_q, scnt_d;
	logic [NG-1:0] start_q, start_d;
	logic first_q, first_d;
	logic [NG-1:0] accept, ignored, ended, busy;

	// ----------------------------------------------------------------
	// Scan group tracking
	// ----------------------------------------------------------------
	scan_group_tracker #(.NG(NG)) u_groups (
		.mclk(mclk),
		.ce(ce),
		.reset(reset),
		.trig(scan_trigger),
		.done(scan_done),
		.accept(accept),
		.ignored(ignored),
		.ended(ended),
		.busy_q(busy)
	);

	// ----------------------------------------------------------------
	// Avalon-MM slave
	// ----------------------------------------------------------------
	// One wait cycle on every access; frozen clock enable keeps it waiting
	assign avs_waitrequest = (avs_read | avs_write) & ~(ack_q & ce);
	assign avs_readdata = rdata_q;

	always_comb begin
		st.samp_count = scnt_q;
		st.samp_state = samp_q;
		st.diag_applied = diag_q;
		st.compare_combined_monitor = mon_c_q;
		st.compare_window_b_monitor = mon_b_q;
		st.compare_window_a_monitor = mon_a_q;
		st.pair_first = pair_first_q;
		rmux = 32'h0000_0000;
		if (avs_address[1:0] == 2'b00) begin
			case (avs_address)
				CTRL_OFFS: rmux = 32'(ctrl_q);
				STATE_OFFS: rmux = 32'(st);
				BUSY_OFFS: rmux = 32'(busy);
				IRQ_STAT_OFFS: rmux = 32'(istat_q);
				IRQ_MASK_OFFS: rmux = 32'(mask_q);
				default: rmux = 32'h0000_0000;
			endcase
		end
		rd_start = avs_read & ~ack_q;
		wr_en = avs_write & ack_q;
		ack_d = (avs_read | avs_write) & ~ack_q;
		rdata_d = rd_start ? rmux : rdata_q;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else if (ce) begin
			ack_q <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Control, mask and interrupt status
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_wr = be_merge(32'(ctrl_q), avs_writedata, avs_byteenable);
		mask_wr = be_merge(32'(mask_q), avs_writedata, avs_byteenable);
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		iclr = '0;
		if (wr_en && addr_hit(avs_address, CTRL_OFFS)) begin
			ctrl_d = ctrl_t'(ctrl_wr[CTRL_W-1:0]);
		end
		if (wr_en && addr_hit(avs_address, IRQ_MASK_OFFS)) begin
			mask_d = mask_wr[IRQ_W-1:0];
		end
		if (wr_en && addr_hit(avs_address, IRQ_STAT_OFFS)) begin
			iclr = avs_writedata[IRQ_W-1:0] & {{(IRQ_W-8){avs_byteenable[1]}},
				{8{avs_byteenable[0]}}};
		end
		// Group end flags feed software's retrigger spacing
		iset = {|ignored, ended};
		// Set wins over a clear in the same cycle
		istat_d = (istat_q & ~iclr) | iset;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_q <= ctrl_t'(CTRL_RESET);
			mask_q <= IRQ_RESET;
			istat_q <= IRQ_RESET;
		end else if (ce) begin
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			istat_q <= istat_d;
		end
	end

	assign irq = |(istat_q & mask_q);

	// ----------------------------------------------------------------
	// Diagnosis voltage, double trigger, compare monitors
	// ----------------------------------------------------------------
	always_comb begin
		diag_d = diag_q;
		// Select only takes effect when the load bit was already set
		if (wr_en && addr_hit(avs_address, CTRL_OFFS) && ctrl_q.diag_voltage_load_enable
			&& avs_byteenable[1]) begin
			diag_d = avs_writedata[9:8];
		end
		any_accept = |accept;
		dbl_rise = ctrl_q.double_trigger_enable & ~dbl_prev_q;
		first_now = dbl_rise | pair_first_q;
		if (!ctrl_q.double_trigger_enable) begin
			pair_first_d = 1'b1;
		end else if (any_accept) begin
			pair_first_d = ~first_now;
		end else begin
			pair_first_d = first_now;
		end
		start_d = accept;
		first_d = any_accept & ctrl_q.double_trigger_enable & first_now;
		mon_a_d = mon_a_q;
		mon_b_d = mon_b_q;
		mon_c_d = mon_c_q;
		if (!ctrl_q.compare_window_a_enable && !ctrl_q.compare_window_b_enable) begin
			mon_a_d = 1'b0;
			mon_b_d = 1'b0;
			mon_c_d = 1'b0;
		end else if (cmp_valid) begin
			mon_a_d = ctrl_q.compare_window_a_enable & cmp_a_hit;
			mon_b_d = ctrl_q.compare_window_b_enable & cmp_b_hit;
			mon_c_d = ctrl_q.combine_or ? (mon_a_d | mon_b_d) : (mon_a_d & mon_b_d);
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			diag_q <= 2'h0;
			dbl_prev_q <= 1'b0;
			pair_first_q <= 1'b1;
			start_q <= '0;
			first_q <= 1'b0;
			mon_a_q <= 1'b0;
			mon_b_q <= 1'b0;
			mon_c_q <= 1'b0;
		end else if (ce) begin
			diag_q <= diag_d;
			dbl_prev_q <= ctrl_q.double_trigger_enable;
			pair_first_q <= pair_first_d;
			start_q <= start_d;
			first_q <= first_d;
			mon_a_q <= mon_a_d;
			mon_b_q <= mon_b_d;
			mon_c_q <= mon_c_d;
		end
	end

	// ----------------------------------------------------------------
	// Constant sampling state
	// ----------------------------------------------------------------
	// Reinit lasts one cycle; re-enabling sooner is only seen afterwards
	always_comb begin
		samp_d = samp_q;
		scnt_d = scnt_q;
		case (samp_q)
			SAMP_IDLE: begin
				if (ctrl_q.constant_sampling_mode) begin
					samp_d = SAMP_RUN;
				end
			end
			SAMP_RUN: begin
				if (!ctrl_q.constant_sampling_mode) begin
					samp_d = SAMP_REINIT;
					scnt_d = '0;
				end else if (any_accept && scnt_q != '1) begin
					scnt_d = scnt_q + 1'b1;
				end
			end
			SAMP_REINIT: begin
				samp_d = SAMP_IDLE;
				scnt_d = '0;
			end
			default: begin
				samp_d = SAMP_IDLE;
				scnt_d = '0;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			samp_q <= SAMP_IDLE;
			scnt_q <= '0;
		end else if (ce) begin
			samp_q <= samp_d;
			scnt_q <= scnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign scan_start = start_q;
	assign scan_first = first_q;
	assign diag_voltage = diag_q;
	assign sync_enable = ctrl_q.sync_operation_control;
	assign da_ad_reduce = ctrl_q.da_ad_interference_reduce;
	assign sampling_enable = (samp_q == SAMP_RUN);
	assign sampling_reinit = (samp_q == SAMP_REINIT);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	sequence s_req_wait;
		ce && (avs_read || avs_write) && avs_waitrequest;
	endsequence

	sequence s_req_done;
		ce && avs_read && !avs_waitrequest;
	endsequence

	a_sync_on_reset: assert property ($fell(reset) |-> sync_enable)
		else $error("sync off after reset");
	a_bus_one_wait: assert property (s_req_wait ##1 ce |-> !avs_waitrequest)
		else $error("wait longer than one cycle");
	a_bus_read_data: assert property (s_req_wait ##1 s_req_done |->
		avs_readdata == $past(rmux))
		else $error("read data mismatch");
	a_mon_clear_both: assert property (ce && !ctrl_q.compare_window_a_enable &&
		!ctrl_q.compare_window_b_enable |=> !mon_a_q && !mon_b_q && !mon_c_q)
		else $error("monitors not cleared");
	a_dbl_rise_first: assert property (ce && dbl_rise && !any_accept |=> pair_first_q)
		else $error("pair not reset to first");
	a_dbl_first_out: assert property (ce && dbl_rise && any_accept |=> scan_first ##1
		(!$past(ce) || !scan_first))
		else $error("first scan not marked");
	a_samp_reinit: assert property (ce && samp_q == SAMP_RUN && !ctrl_q.constant_sampling_mode
		|=> sampling_reinit && scnt_q == '0 ##1 (!$past(ce) || samp_q == SAMP_IDLE))
		else $error("sampling not reinitialised");
	a_diag_load: assert property (ce && wr_en && addr_hit(avs_address, CTRL_OFFS) &&
		ctrl_q.diag_voltage_load_enable && avs_byteenable[1] |=>
		diag_voltage == $past(avs_writedata[9:8]))
		else $error("diag voltage not applied");
	a_diag_hold: assert property (ce && !ctrl_q.diag_voltage_load_enable |=> $stable(diag_q))
		else $error("diag voltage changed unloaded");
	a_irq_set_wins: assert property (ce && iset[0] && iclr[0] |=> istat_q[0])
		else $error("event lost under clear");
	a_ignored_flag: assert property (ce && ((scan_trigger & busy) != '0) |=>
		istat_q[IRQ_IGNORED_BIT])
		else $error("ignored trigger not flagged");

endmodule : adc_scan_seq_ctrl

`default_nettype wire

// File: src/adc_seq_pkg.sv
// Shared constants, layouts and types for the scan sequencing control.
// Assumes a single converter clock domain; all users import this package.

package adc_seq_pkg;

	// ----------------------------------------------------------------
	// Sizes and timing
	// ----------------------------------------------------------------
	localparam int NUM_GROUPS = 9;
	localparam int CLK_PERIOD_NS = 50;
	localparam int REARM_GAP_NS = 50;
	localparam int REARM_GAP_CYC = (REARM_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMP_CNT_W = 4;

	// ----------------------------------------------------------------
	// Register map, byte addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_OFFS = 8'h00;
	localparam logic [7:0] STATE_OFFS = 8'h04;
	localparam logic [7:0] BUSY_OFFS = 8'h08;
	localparam logic [7:0] IRQ_STAT_OFFS = 8'h0C;
	localparam logic [7:0] IRQ_MASK_OFFS = 8'h10;

	// ----------------------------------------------------------------
	// Field layouts
	// ----------------------------------------------------------------
	localparam int CTRL_W = 10;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h010;
	localparam int STATE_W = 13;
	localparam int IRQ_W = NUM_GROUPS + 1;
	localparam int IRQ_IGNORED_BIT = NUM_GROUPS;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 10'h000;

	typedef struct packed {
		logic [1:0] diag_voltage_select;
		logic combine_or;
		logic diag_voltage_load_enable;
		logic da_ad_interference_reduce;
		logic sync_operation_control;
		logic constant_sampling_mode;
		logic compare_window_b_enable;
		logic compare_window_a_enable;
		logic double_trigger_enable;
	} ctrl_t;

	typedef enum logic [2:0] {
		SAMP_IDLE = 3'b001,
		SAMP_RUN = 3'b010,
		SAMP_REINIT = 3'b100
	} samp_state_t;

	typedef struct packed {
		logic [SAMP_CNT_W-1:0] samp_count;
		samp_state_t samp_state;
		logic [1:0] diag_applied;
		logic compare_combined_monitor;
		logic compare_window_b_monitor;
		logic compare_window_a_monitor;
		logic pair_first;
	} state_t;

endpackage : adc_seq_pkg

// File: src/scan_group_tracker.sv
// Per scan group busy tracking and start trigger acceptance.
// Assumes triggers and done pulses are one-cycle pulses on mclk.

`timescale 1ns/1ps
`default_nettype none

module scan_group_tracker #(
	parameter int NG = adc_seq_pkg::NUM_GROUPS
) (
	input wire logic mclk,
	input wire logic ce,
	input wire logic reset,
	input wire logic [NG-1:0] trig,
	input wire logic [NG-1:0] done,
	output logic [NG-1:0] accept,
	output logic [NG-1:0] ignored,
	output logic [NG-1:0] ended,
	output logic [NG-1:0] busy_q
);
	import adc_seq_pkg::*;

	logic [NG-1:0] busy_d;

	// ----------------------------------------------------------------
	// Acceptance
	// ----------------------------------------------------------------
	// A trigger meeting a running scan is dropped, not queued
	always_comb begin
		accept = trig & ~busy_q;
		ignored = trig & busy_q;
		ended = done & busy_q;
		busy_d = (busy_q & ~done) | accept;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			busy_q <= '0;
		end else if (ce) begin
			busy_q <= busy_d;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);

	a_busy_after_accept: assert property (ce && (accept != '0) |=>
		((busy_q & $past(accept)) == $past(accept)))
		else $error("accepted group not busy");
	a_busy_drops_trig: assert property (ce && ((trig & busy_q) != '0) && (done == '0) |->
		((accept & trig & busy_q) == '0) ##1 ((busy_q & $past(trig)) == $past(trig)))
		else $error("busy group took a trigger");

endmodule : scan_group_tracker

`default_nettype wire
